/* src/isb_pkg.sv */
// Package for the two-wire status, baud and address-match block
package isb_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_BUS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CLOCK_DIV    = 8'h04;
  localparam logic [7:0] OFS_OWN_IDENT    = 8'h08;
  localparam logic [7:0] OFS_MATCH_MASK   = 8'h0C;
  localparam logic [7:0] OFS_RX_HOLDING   = 8'h10;
  localparam logic [7:0] OFS_TX_HOLDING   = 8'h14;
  localparam logic [7:0] OFS_CONTROL      = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h20;
  // Status bit positions
  localparam int BIT_STOP     = 4;
  localparam int BIT_START    = 3;
  localparam int BIT_DIR      = 2;
  localparam int BIT_RX_FULL  = 1;
  localparam int BIT_TX_FULL  = 0;
  // Control bit positions
  localparam int BIT_TEN_BIT  = 10;
  localparam int BIT_ENABLE   = 0;
  // Field widths
  localparam int DIV_W   = 12;
  localparam int IDENT_W = 10;
  localparam int IRQ_W   = 5;
  // Reset values
  localparam logic [DIV_W-1:0]   DIV_RESET   = 12'h000;
  localparam logic [IDENT_W-1:0] IDENT_RESET = 10'h000;
  localparam logic [IDENT_W-1:0] MASK_RESET  = 10'h000;
  // Interrupt event positions
  localparam int EV_START = 0;
  localparam int EV_STOP  = 1;
  localparam int EV_RX    = 2;
  localparam int EV_TX    = 3;
  localparam int EV_MATCH = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ISB_LS_IDLE,
    ISB_LS_SHIFT,
    ISB_LS_ACK
  } isb_link_st_t;

  // Pin group for one open-drain line
  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } isb_pin_t;

  // Bus-condition event group
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } isb_cond_t;
endpackage

/* src/isb_status_baud_match.sv */
// Status flags, baud divider, own-address match and register slave
`timescale 1ns/1ps
`default_nettype none
module isb_status_baud_match
  import isb_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [7:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [7:0]        s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_o,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  output logic                   baud_tick_o,
  output logic                   irq_o
);
  import isb_pkg::*;

  // Two-flop synchronisers on the pins; the first stage feeds only the second
  logic [1:0] scl_meta, sda_meta;
  logic [1:0] scl_sync, sda_sync;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_meta <= 2'b11;
      sda_meta <= 2'b11;
    end else begin
      scl_meta <= {scl_meta[0], scl_i};
      sda_meta <= {sda_meta[0], sda_i};
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
    end else begin
      scl_sync <= {scl_sync[0], scl_meta[1]};
      sda_sync <= {sda_sync[0], sda_meta[1]};
    end
  end

  // Bus conditions: second stage (new) against the stage after it (old); comparing
  // deeper stages makes the acknowledge release too late for a short clock low phase
  isb_cond_t cond;
  always_comb begin
    cond.start = scl_sync[0] && scl_meta[1] && sda_sync[0] && !sda_meta[1];
    cond.stop  = scl_sync[0] && scl_meta[1] && !sda_sync[0] && sda_meta[1];
    cond.rise  = !scl_sync[0] && scl_meta[1];
    cond.fall  = scl_sync[0] && !scl_meta[1];
  end

  // Register state
  logic [DIV_W-1:0]   clock_divider, next_clock_divider;
  logic [IDENT_W-1:0] own_slave_ident, next_own_slave_ident;
  logic [IDENT_W-1:0] match_mask, next_match_mask;
  logic               ten_bit_ident_select, next_ten_bit_ident_select;
  logic               enable, next_enable;
  logic [7:0]         tx_holding_reg, next_tx_holding_reg;
  logic [7:0]         rx_holding_reg, next_rx_holding_reg;
  logic               stop_seen, next_stop_seen;
  logic               start_seen, next_start_seen;
  logic               dir_read, next_dir_read;
  logic               rx_holding_full, next_rx_holding_full;
  logic               tx_holding_full, next_tx_holding_full;
  logic [IRQ_W-1:0]   irq_status, next_irq_status;
  logic [IRQ_W-1:0]   irq_mask, next_irq_mask;

  // Bus channel state
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic        wr_fire, rd_fire;
  logic        wr_hit, rd_hit;
  logic [31:0] rd_word;

  // Link state
  isb_link_st_t link_st, next_link_st;
  logic [3:0]   bit_cnt, next_bit_cnt;
  logic [7:0]   shreg, next_shreg;
  logic         first_byte, next_first_byte;
  logic         tx_active, next_tx_active;
  logic         addr_match, next_addr_match;
  logic         ev_start, ev_stop, ev_rx, ev_tx, ev_match;

  // Baud generator
  logic [DIV_W-1:0] baud_cnt, next_baud_cnt;
  logic             baud_tick, next_baud_tick;
  logic             scl_drv, next_scl_drv;

  // Address compare; mask one means don't care, bits 9, 8 and 0 ignored in both modes
  logic [IDENT_W-1:0] eff_mask;
  logic [IDENT_W-1:0] rx_ident;
  logic               ident_hit;
  always_comb begin
    eff_mask = match_mask;
    if (!ten_bit_ident_select) begin
      eff_mask[9] = 1'b0;
      eff_mask[8] = 1'b0;
      eff_mask[0] = 1'b0;
    end
    // Seven-bit address sits in bits 7:1 of the first byte
    rx_ident  = {2'b00, shreg[7:1], 1'b0};
    ident_hit = ((rx_ident ^ own_slave_ident) & ~eff_mask &
                 (ten_bit_ident_select ? 10'h0FE : 10'h0FE)) == 10'h000;
  end

  // Bus handshake decode
  always_comb begin
    rd_fire = s_axi_arvalid_i && !rvalid;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    if (s_axi_awvalid_i && !aw_held && !bvalid) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_held && !bvalid) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    // Write from the held words, so address and data are the ones captured
    wr_fire = aw_held && w_held && !bvalid;
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
  end

  // Read data mux; unmapped offsets answer with an error
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr_i)
      OFS_BUS_STATUS: rd_word = {27'h000_0000, stop_seen, start_seen, dir_read,
                                 rx_holding_full, tx_holding_full};
      OFS_CLOCK_DIV:  rd_word = {20'h0_0000, clock_divider};
      OFS_OWN_IDENT:  rd_word = {22'h00_0000, own_slave_ident};
      OFS_MATCH_MASK: rd_word = {22'h00_0000, match_mask};
      OFS_RX_HOLDING: rd_word = {24'h00_0000, rx_holding_reg};
      OFS_TX_HOLDING: rd_word = {24'h00_0000, tx_holding_reg};
      OFS_CONTROL:    rd_word = {21'h00_0000, ten_bit_ident_select, 9'h000, enable};
      OFS_IRQ_STATUS: rd_word = {27'h000_0000, irq_status};
      OFS_IRQ_MASK:   rd_word = {27'h000_0000, irq_mask};
      default:        rd_hit  = 1'b0;
    endcase
  end

  // Register writes, flags and interrupts; hardware set wins over a clear
  always_comb begin
    next_clock_divider        = clock_divider;
    next_own_slave_ident      = own_slave_ident;
    next_match_mask           = match_mask;
    next_ten_bit_ident_select = ten_bit_ident_select;
    next_enable               = enable;
    next_tx_holding_reg       = tx_holding_reg;
    next_irq_mask             = irq_mask;
    next_bvalid = bvalid && !s_axi_bready_i;
    next_bresp  = bresp;
    next_rvalid = rvalid && !s_axi_rready_i;
    next_rresp  = rresp;
    next_rdata  = rdata;
    next_tx_holding_full = tx_holding_full;
    next_rx_holding_full = rx_holding_full;
    next_irq_status      = irq_status;
    wr_hit = 1'b1;
    if (wr_fire) begin
      next_bvalid = 1'b1;
      case (aw_addr)
        OFS_CLOCK_DIV:  if (w_strb[0]) next_clock_divider = w_data[DIV_W-1:0];
        OFS_OWN_IDENT:  if (w_strb[0]) next_own_slave_ident = w_data[IDENT_W-1:0];
        OFS_MATCH_MASK: if (w_strb[0]) next_match_mask = w_data[IDENT_W-1:0];
        OFS_CONTROL: if (w_strb[1]) begin
          next_ten_bit_ident_select = w_data[BIT_TEN_BIT];
          next_enable = w_data[BIT_ENABLE];
        end
        OFS_TX_HOLDING: if (w_strb[0]) begin
          next_tx_holding_reg  = w_data[7:0];
          next_tx_holding_full = 1'b1;
        end
        OFS_IRQ_STATUS: if (w_strb[0]) next_irq_status = irq_status & ~w_data[IRQ_W-1:0];
        OFS_IRQ_MASK:   if (w_strb[0]) next_irq_mask = w_data[IRQ_W-1:0];
        OFS_BUS_STATUS, OFS_RX_HOLDING: ;
        default: wr_hit = 1'b0;
      endcase
      next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr_i == OFS_RX_HOLDING)
        next_rx_holding_full = 1'b0;
    end
    if (ev_tx)
      next_tx_holding_full = 1'b0;
    if (ev_rx)
      next_rx_holding_full = 1'b1;
    next_irq_status = next_irq_status |
      {ev_match, ev_tx, ev_rx, ev_stop, ev_start};
  end

  // Bus link: byte framing, receive, transmit and address match
  always_comb begin
    next_link_st    = link_st;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_first_byte = first_byte;
    next_tx_active  = tx_active;
    next_addr_match = addr_match;
    next_dir_read   = dir_read;
    next_rx_holding_reg = rx_holding_reg;
    next_stop_seen  = stop_seen;
    next_start_seen = start_seen;
    ev_start = 1'b0;
    ev_stop  = 1'b0;
    ev_rx    = 1'b0;
    ev_tx    = 1'b0;
    ev_match = 1'b0;
    if (enable) begin
      if (cond.start) begin
        next_start_seen = 1'b1;
        next_stop_seen  = 1'b0;
        ev_start        = 1'b1;
        next_link_st    = ISB_LS_SHIFT;
        next_bit_cnt    = 4'h0;
        next_first_byte = 1'b1;
        next_addr_match = 1'b0;
        next_tx_active  = 1'b0;
      end else if (cond.stop) begin
        next_stop_seen  = 1'b1;
        next_start_seen = 1'b0;
        ev_stop         = 1'b1;
        next_link_st    = ISB_LS_IDLE;
        next_tx_active  = 1'b0;
      end else begin
        case (link_st)
          ISB_LS_IDLE: ;
          ISB_LS_SHIFT: begin
            // Sent data follows the holding register until the first rise, then moves on falls
            if (tx_active && bit_cnt == 4'h0)
              next_shreg = tx_holding_reg;
            if (cond.fall && tx_active && bit_cnt != 4'h0)
              next_shreg = {shreg[6:0], 1'b0};
            if (cond.rise) begin
              if (!tx_active)
                next_shreg = {shreg[6:0], sda_meta[1]};
              next_bit_cnt = bit_cnt + 4'h1;
            end
            if (bit_cnt == 4'h8 && cond.fall) begin
              next_link_st = ISB_LS_ACK;
              if (first_byte) begin
                next_first_byte = 1'b0;
                if (ident_hit) begin
                  next_addr_match = 1'b1;
                  ev_match        = 1'b1;
                  next_dir_read   = shreg[0];
                end
              end else if (tx_active) begin
                ev_tx = 1'b1;
              end else if (addr_match) begin
                next_rx_holding_reg = shreg;
                ev_rx = 1'b1;
              end
            end
          end
          ISB_LS_ACK: begin
            // A released line after a sent byte means the master wants no more data
            if (cond.rise && tx_active && sda_meta[1])
              next_addr_match = 1'b0;
            if (cond.fall) begin
              next_link_st   = addr_match ? ISB_LS_SHIFT : ISB_LS_IDLE;
              next_bit_cnt   = 4'h0;
              next_tx_active = addr_match && dir_read;
            end
          end
          default: next_link_st = ISB_LS_IDLE;
        endcase
      end
    end
  end

  // Baud generator: reload then count down, one tick per serial half period
  always_comb begin
    next_baud_tick = 1'b0;
    next_baud_cnt  = baud_cnt;
    next_scl_drv   = scl_drv;
    if (!enable) begin
      next_baud_cnt = clock_divider;
      next_scl_drv  = 1'b0;
    end else if (baud_cnt == DIV_RESET) begin
      next_baud_cnt  = clock_divider;
      next_baud_tick = 1'b1;
      next_scl_drv   = !scl_drv;
    end else begin
      next_baud_cnt = baud_cnt - 12'h001;
    end
  end

  // Single register stage for all register, bus channel, link and baud generator state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clock_divider <= DIV_RESET;
      own_slave_ident <= IDENT_RESET;
      match_mask <= MASK_RESET;
      ten_bit_ident_select <= 1'b0;
      enable <= 1'b0;
      tx_holding_reg <= 8'h00;
      rx_holding_reg <= 8'h00;
      stop_seen <= 1'b0;
      start_seen <= 1'b0;
      dir_read <= 1'b0;
      rx_holding_full <= 1'b0;
      tx_holding_full <= 1'b0;
      irq_status <= 5'h00;
      irq_mask <= 5'h00;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
      link_st <= ISB_LS_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      first_byte <= 1'b0;
      tx_active <= 1'b0;
      addr_match <= 1'b0;
      baud_cnt <= DIV_RESET;
      baud_tick <= 1'b0;
      scl_drv <= 1'b0;
    end else begin
      clock_divider <= next_clock_divider;
      own_slave_ident <= next_own_slave_ident;
      match_mask <= next_match_mask;
      ten_bit_ident_select <= next_ten_bit_ident_select;
      enable <= next_enable;
      tx_holding_reg <= next_tx_holding_reg;
      rx_holding_reg <= next_rx_holding_reg;
      stop_seen <= next_stop_seen;
      start_seen <= next_start_seen;
      dir_read <= next_dir_read;
      rx_holding_full <= next_rx_holding_full;
      tx_holding_full <= next_tx_holding_full;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      link_st <= next_link_st;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      first_byte <= next_first_byte;
      tx_active <= next_tx_active;
      addr_match <= next_addr_match;
      baud_cnt <= next_baud_cnt;
      baud_tick <= next_baud_tick;
      scl_drv <= next_scl_drv;
    end
  end

  // Registered outputs; pins are open drain, never driven high
  isb_pin_t scl_pin, sda_pin;
  logic     irq_q, awr_q, wr_q, sda_oe_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_q    <= 1'b0;
      awr_q    <= 1'b0;
      wr_q     <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      irq_q    <= |(next_irq_status & next_irq_mask);
      awr_q    <= !next_aw_held && !next_bvalid;
      wr_q     <= !next_w_held && !next_bvalid;
      // Drive low for the acknowledge of a matched byte or a zero data bit
      sda_oe_q <= (next_link_st == ISB_LS_ACK && (next_addr_match && !next_tx_active)) ||
                  (next_link_st == ISB_LS_SHIFT && next_tx_active && !next_first_byte &&
                   !next_shreg[7]);
    end
  end
  always_comb begin
    scl_pin = '{in: scl_sync[1], out: 1'b0, oe: 1'b0};
    sda_pin = '{in: sda_sync[1], out: 1'b0, oe: sda_oe_q};
  end

  assign s_axi_awready_o = awr_q;
  assign s_axi_wready_o  = wr_q;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rresp_o   = rresp;
  assign s_axi_rdata_o   = rdata;
  assign scl_o           = scl_pin.out;
  assign scl_oe_o        = scl_drv && 1'b0;
  assign sda_o           = sda_pin.out;
  assign sda_oe_o        = sda_pin.oe;
  assign baud_tick_o     = baud_tick;
  assign irq_o           = irq_q;
endmodule // isb_status_baud_match
`default_nettype wire

/* tb/isb_status_baud_match_asserts.sv */
// Checker for register bus handshakes, read-back widths and pin levels
`timescale 1ns/1ps
`default_nettype none
module isb_sbm_asserts
  import isb_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_o,
  input wire logic        sda_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [7:0] rd_addr;
  logic [7:0] next_rd_addr;
  // Read data carries no address, so remember the one taken
  always_comb begin
    next_rd_addr = rd_addr;
    if (s_axi_arvalid_i && s_axi_arready_o) next_rd_addr = s_axi_araddr_i;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rd_addr <= 8'h00;
    else rd_addr <= next_rd_addr;
  end
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_first;
    $rose(s_axi_rvalid_o);
  endsequence
  wr_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid_o) else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
  ar_gate_a: assert property (s_axi_arready_o == !s_axi_rvalid_o) else $error("arready not gated");
  cond_excl_a: assert property (rd_first ##0 (rd_addr == OFS_BUS_STATUS) |->
    !(s_axi_rdata_o[BIT_STOP] && s_axi_rdata_o[BIT_START])) else $error("start and stop both set");
  div_top_a: assert property (rd_first ##0 (rd_addr == OFS_CLOCK_DIV) |->
    s_axi_rdata_o[31:12] == 20'h0_0000) else $error("divider upper bits set");
  ident_top_a: assert property (rd_first ##0 (rd_addr == OFS_OWN_IDENT || rd_addr == OFS_MATCH_MASK) |->
    s_axi_rdata_o[31:10] == 22'h00_0000) else $error("address upper bits set");
  pin_idle_a: assert property (!scl_oe_o && !scl_o && !sda_o) else $error("pin driven high");
endmodule // isb_sbm_asserts
bind isb_status_baud_match isb_sbm_asserts i_isb_sbm_asserts (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o));
`default_nettype wire

/* tb/isb_bus_peer.sv */
// Two-wire bus master model standing at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module isb_bus_peer (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  // Both lines released at rest; the clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Data line falls while the clock is high; called on clock edges, so lines move by
  // non-blocking assignment after the block has sampled them
  task automatic start_c();
    sda_low_o <= 1'b1;
    #32;
    scl_o <= 1'b0;
    #8;
  endtask
  // Data line rises while the clock is high
  task automatic stop_c();
    sda_low_o <= 1'b1;
    #24;
    scl_o <= 1'b1;
    #32;
    sda_low_o <= 1'b0;
    #32;
  endtask
  // Eight bits msb first, then the acknowledge slot; data moves only with the clock low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda_low_o <= (i >= 0) ? ~tx[i] : 1'b0;
      #24;
      scl_o <= 1'b1;
      #16;
      if (i >= 0) rx[i] = sda_i;
      else ack = ~sda_i;
      #16;
      scl_o <= 1'b0;
      #8;
    end
  endtask
endmodule // isb_bus_peer
`default_nettype wire

/* tb/isb_status_baud_match_tb_top.sv */
// Self-checking bench for the status, baud and address-match block
`timescale 1ns/1ps
`default_nettype none
module isb_status_baud_match_tb_top;
  import isb_pkg::*;
  logic        clk_i = 1'b0, arst_n_i = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rx;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd_val;
  logic        awready, wready, bvalid, arready, rvalid, scl_o, scl_oe_o, sda_o, sda_oe_o, tick, irq_o;
  logic        peer_scl, peer_low, ack;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp;
  wire logic   scl_w = peer_scl & ~scl_oe_o;
  wire logic   sda_w = ~(peer_low | sda_oe_o); // Pull-up on the data line
  int          miscompares = 0, num_checks = 0;
  always #4 clk_i = ~clk_i;
  isb_status_baud_match i_isb_status_baud_match (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .baud_tick_o(tick), .irq_o(irq_o));
  isb_bus_peer i_isb_bus_peer (.scl_o(peer_scl), .sda_low_o(peer_low), .sda_i(sda_w));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_val = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask
  // Status read through a bit mask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    rd(OFS_BUS_STATUS);
    chk(rd_val & m, e);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reset values, writable widths and an unmapped offset
  task automatic t_regs();
    logic [7:0]  ofs [3] = '{OFS_CLOCK_DIV, OFS_OWN_IDENT, OFS_MATCH_MASK};
    logic [31:0] top [3] = '{32'h0000_0FFF, 32'h0000_03FF, 32'h0000_03FF};
    st(32'hFFFF_FFFF, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      rd(ofs[i]);
      chk(rd_val, 32'h0000_0000);
      wr(ofs[i], 32'hFFFF_FFFF);
      rd(ofs[i]);
      chk(rd_val, top[i]);
    end
    wr(8'h40, 32'h0000_0001);
    chk(32'(wr_resp), 32'(RESP_SLVERR));
    rd(8'h40);
    chk({rd_val[29:0], rd_resp}, 32'(RESP_SLVERR));
    $display("t_regs end");
  endtask
  // Start and stop flags, masked interrupt, status clear by writing ones
  task automatic t_cond();
    wr(OFS_CONTROL, 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    i_isb_bus_peer.start_c();
    st(32'h0000_0018, 32'h0000_0008);
    i_isb_bus_peer.stop_c();
    st(32'h0000_0018, 32'h0000_0010);
    rd(OFS_IRQ_STATUS);
    chk(rd_val & 32'h0000_0003, 32'h0000_0003);
    chk(32'(irq_o), 32'h0000_0000);
    wr(OFS_IRQ_STATUS, 32'h0000_001F);
    rd(OFS_IRQ_STATUS);
    chk(rd_val, 32'h0000_0000);
    $display("t_cond end");
  endtask
  // Address miss then masked hit, written byte, read-clear of receive-full
  task automatic t_match();
    wr(OFS_OWN_IDENT, 32'h0000_00FF);
    wr(OFS_MATCH_MASK, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0010);
    i_isb_bus_peer.start_c();
    i_isb_bus_peer.xfer(8'h7E, rx, ack);
    chk(32'(ack), 32'h0000_0000);
    i_isb_bus_peer.stop_c();
    chk(32'(irq_o), 32'h0000_0000);
    wr(OFS_MATCH_MASK, 32'h0000_00C0);
    i_isb_bus_peer.start_c();
    i_isb_bus_peer.xfer(8'h7E, rx, ack);
    chk(32'(ack), 32'h0000_0001);
    st(32'h0000_0004, 32'h0000_0000);
    chk(32'(irq_o), 32'h0000_0001);
    i_isb_bus_peer.xfer(8'hA5, rx, ack);
    st(32'h0000_0002, 32'h0000_0002);
    rd(OFS_RX_HOLDING);
    chk(rd_val, 32'h0000_00A5);
    st(32'h0000_0002, 32'h0000_0000);
    i_isb_bus_peer.stop_c();
    wr(OFS_IRQ_STATUS, 32'h0000_001F);
    rd(OFS_IRQ_STATUS);
    chk({rd_val[30:0], irq_o}, 32'h0000_0000);
    $display("t_match end");
  endtask
  // Read address, then one byte sent from the transmit holding register
  task automatic t_read();
    i_isb_bus_peer.start_c();
    i_isb_bus_peer.xfer(8'hFF, rx, ack);
    chk(32'(ack), 32'h0000_0001);
    st(32'h0000_0004, 32'h0000_0004);
    wr(OFS_TX_HOLDING, 32'h0000_003C);
    st(32'h0000_0001, 32'h0000_0001);
    i_isb_bus_peer.xfer(8'hFF, rx, ack);
    chk(32'(rx), 32'h0000_003C);
    st(32'h0000_0001, 32'h0000_0000);
    i_isb_bus_peer.stop_c();
    $display("t_read end");
  endtask
  // Smallest legal reload gives one tick every four cycles
  task automatic t_baud();
    int n;
    wr(OFS_CLOCK_DIV, 32'h0000_0003);
    do @(posedge clk_i); while (tick !== 1'b1);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1);
    chk(n, 32'h0000_0004);
    $display("t_baud end");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_cond();
    t_match();
    t_read();
    t_baud();
    close_out();
  end
  // Watchdog far above the expected run of about 33 us
  initial begin
    #200_000;
    miscompares++;
    close_out();
  end
endmodule // isb_status_baud_match_tb_top
`default_nettype wire
